// File: iep_regs.svh
/*
 * register map, field positions, reset values and masks of the interrupt
 * enable/priority register block.
 * assumes: included by its bare name after the package, byte addressing.
 */
`ifndef IEP_REGS_SVH
`define IEP_REGS_SVH

// byte offsets inside the block window
`define IEP_FLAG_OFS 8'h00
`define IEP_EN_OFS 8'h04
`define IEP_PRIO_BASE 8'h10

// one priority control word carries four source slots
`define IEP_SLOTS_PER_WORD 4
`define IEP_SLOT_STRIDE 8
`define IEP_PRIO_LSB 2
`define IEP_PRIO_W 3
`define IEP_SUB_LSB 0
`define IEP_SUB_W 2

// implemented bits of a priority control word; 31:29, 23:21, 15:13 and
// 7:5 are not implemented
`define IEP_PRIO_IMPL_MASK 32'h1f1f1f1f

// reset values
`define IEP_PRIO_RESET 32'h00000000
`define IEP_EN_RESET 32'h00000000
`define IEP_FLAG_RESET 32'h00000000

`endif

// File: iep_pkg.sv
/*
 * types shared by the interrupt enable/priority register block.
 * assumes: compiled before any module that names iep_pkg.
 */
package iep_pkg;

    // latched ahb address phase
    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
    } iep_aphase_type;

    // ranked request presented to the processor core
    typedef struct packed {
        logic valid;
        logic [4:0] src;
        logic [2:0] prio;
        logic [1:0] sub;
    } iep_req_type;

endpackage

// File: iep_ctrl.sv
/*
 * interrupt enable / priority register block with an ahb-lite slave port.
 * holds the request flag word, the source enable word and the priority
 * control words, and ranks pending sources for the processor core.
 * assumes: one clock hclk, asynchronous active-low reset, source requests
 * are one-cycle or level pulses from logic on hclk, single-word accesses.
 */
`timescale 1ns/1ps
`include "iep_regs.svh"

// Contract
// [R1] an enable bit of one lets its source through, zero blocks it
// [R2] enable word is 32 plain read/write bits, one per source
// [R3] priority field 1 to 7 gives that numeric priority
// [R4] priority field zero disables the source entirely
// [R5] two-bit subpriority field encodes subpriority 0 to 3 directly
// [R6] slot 3 priority sits in bits 28 to 26
// [R7] slot 3 subpriority sits in bits 25 to 24
// [R8] slot 2 priority sits in bits 20 to 18
// [R9] slot 2 subpriority sits in bits 17 to 16
// [R10] slot 1 priority sits in bits 12 to 10
// [R11] slot 1 subpriority sits in bits 9 to 8
// [R12] slot 0 priority sits in bits 4 to 2
// [R13] slot 0 subpriority sits in bits 1 to 0
// [R14] priority word bits 31 to 29 ignore writes and read zero
// [R15] priority word bits 23 to 21 ignore writes and read zero
// [R16] priority word bits 15 to 13 ignore writes and read zero
// [R17] a flag bit reads one once its source has requested
// [R18] after reset all enables, priorities and subpriorities are zero
// [R19] highest pending enabled priority goes to core, subpriority breaks ties
module iep_ctrl #(
    parameter int NUM_SRC = 32
)
(
    input wire logic hclk, // system clock, 10 MHz
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // one for write
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic [NUM_SRC-1:0] src_req, // source request pulses
    output logic irq, // level, any ranked source pending
    output iep_pkg::iep_req_type core_req // ranked request to core
);

    localparam int NUM_WORD = NUM_SRC / `IEP_SLOTS_PER_WORD;
    localparam int IDX_W = $clog2(NUM_WORD);
    localparam int KEY_W = `IEP_PRIO_W + `IEP_SUB_W;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    iep_pkg::iep_aphase_type aph_r;
    logic [NUM_SRC-1:0] flag_r;
    logic [NUM_SRC-1:0] en_r;
    logic [31:0] prio_r [NUM_WORD];
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic irq_r;
    iep_pkg::iep_req_type req_r;
    iep_pkg::iep_req_type req_nxt;
    logic [31:0] rd_nxt;
    logic [NUM_SRC-1:0] cand;
    logic [NUM_SRC-1:0] nz_vec;
    logic [KEY_W-1:0] best_key;
    logic wr_flag;
    logic wr_en;
    logic wr_prio;
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;
    logic take;

    // true when a byte address hits one of the priority control words
    function automatic logic is_prio(input logic [7:0] a);
        int off;
        off = int'(a) - int'(`IEP_PRIO_BASE);
        return (a[1:0] == 2'b00) && (off >= 0) && (off < 4 * NUM_WORD);
    endfunction

    // index of the priority control word at a byte address
    function automatic logic [IDX_W-1:0] prio_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - `IEP_PRIO_BASE;
        return off[IDX_W+1:2];
    endfunction

    // {priority, subpriority} key of one source from its control word
    // [R6] [R7] [R8] [R9] slot fields
    // [R10] [R11] [R12] [R13] slot fields
    function automatic logic [KEY_W-1:0] key_of(input logic [31:0] w,
                                                input logic [1:0] slot);
        return w[`IEP_SLOT_STRIDE * slot +: KEY_W];
    endfunction

    // priority field of one slot; a select on a call result is not legal,
    // so the field gets a function of its own
    // [R3] three-bit priority
    function automatic logic [`IEP_PRIO_W-1:0] prio_of(input logic [31:0] w,
                                                       input logic [1:0] slot);
        return w[`IEP_SLOT_STRIDE * slot + `IEP_PRIO_LSB +: `IEP_PRIO_W];
    endfunction

    // subpriority field of one slot of a control word
    // [R5] two-bit subpriority
    function automatic logic [`IEP_SUB_W-1:0] sub_of(input logic [31:0] w,
                                                     input logic [1:0] slot);
        return w[`IEP_SLOT_STRIDE * slot + `IEP_SUB_LSB +: `IEP_SUB_W];
    endfunction

    // a request is taken on a selected non-sequential or sequential phase
    assign take = hsel && hready && htrans[1] && (haddr[31:8] == 24'h000000);

    // decode of the write in its data phase
    assign wr_flag = aph_r.sel && aph_r.wr && (aph_r.addr == `IEP_FLAG_OFS);
    assign wr_en = aph_r.sel && aph_r.wr && (aph_r.addr == `IEP_EN_OFS);
    assign wr_prio = aph_r.sel && aph_r.wr && is_prio(aph_r.addr);
    assign wr_idx = prio_idx(aph_r.addr);
    assign rd_idx = prio_idx(haddr[7:0]);

    // address phase capture; idle or unselected cycles clear its sel bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aph_r <= '0;
        end
        else if (hready)
        begin
            aph_r.sel <= take;
            aph_r.wr <= hwrite;
            aph_r.addr <= haddr[7:0];
        end
    end

    // zero wait states: the slave is ready from the first clock edge after reset and always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_r <= 1'b0;
        end
        else
        begin
            hreadyout_r <= 1'b1;
        end
    end

    // request flags: sticky, write one to clear, a new request beats
    // the clear in the same cycle so no event is lost
    // [R17] flag set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flag_r <= NUM_SRC'(`IEP_FLAG_RESET);
        end
        else if (wr_flag)
        begin
            flag_r <= (flag_r & ~hwdata[NUM_SRC-1:0]) | src_req;
        end
        else
        begin
            flag_r <= flag_r | src_req;
        end
    end

    flag_set_a: assert property ( // R17
        1'b1 |=> ((flag_r & $past(src_req)) == $past(src_req)))
        else $error("request pulse did not set its flag");

    // source enable word, plain storage
    // [R2] enable word write
    // [R18] enables reset zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_r <= NUM_SRC'(`IEP_EN_RESET);
        end
        else if (wr_en)
        begin
            en_r <= hwdata[NUM_SRC-1:0];
        end
    end

    en_write_a: assert property ( // R2
        wr_en |=> (en_r == $past(hwdata[NUM_SRC-1:0])))
        else $error("enable word did not take written value");

    // priority control words; unimplemented bits never store, so they
    // read back as zero without a separate read mask
    // [R14] [R15] [R16] drop reserved bits
    // [R18] priorities reset zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NUM_WORD; i++)
            begin
                prio_r[i] <= `IEP_PRIO_RESET;
            end
        end
        else if (wr_prio)
        begin
            prio_r[wr_idx] <= hwdata & `IEP_PRIO_IMPL_MASK;
        end
    end

    slot3_write_a: assert property ( // R6
        wr_prio |=> (prio_r[$past(wr_idx)][28:26] == $past(hwdata[28:26])))
        else $error("slot 3 priority not stored at bits 28 to 26");

    slot3_sub_a: assert property ( // R7
        wr_prio |=> (prio_r[$past(wr_idx)][25:24] == $past(hwdata[25:24])))
        else $error("slot 3 subpriority not stored at bits 25 to 24");

    slot2_prio_a: assert property ( // R8
        wr_prio |=> (prio_r[$past(wr_idx)][20:18] == $past(hwdata[20:18])))
        else $error("slot 2 priority not stored at bits 20 to 18");

    slot2_sub_a: assert property ( // R9
        wr_prio |=> (prio_r[$past(wr_idx)][17:16] == $past(hwdata[17:16])))
        else $error("slot 2 subpriority not stored at bits 17 to 16");

    slot1_prio_a: assert property ( // R10
        wr_prio |=> (prio_r[$past(wr_idx)][12:10] == $past(hwdata[12:10])))
        else $error("slot 1 priority not stored at bits 12 to 10");

    slot1_sub_a: assert property ( // R11
        wr_prio |=> (prio_r[$past(wr_idx)][9:8] == $past(hwdata[9:8])))
        else $error("slot 1 subpriority not stored at bits 9 to 8");

    slot0_prio_a: assert property ( // R12
        wr_prio |=> (prio_r[$past(wr_idx)][4:2] == $past(hwdata[4:2])))
        else $error("slot 0 priority not stored at bits 4 to 2");

    slot0_sub_a: assert property ( // R13
        wr_prio |=> (prio_r[$past(wr_idx)][1:0] == $past(hwdata[1:0])))
        else $error("slot 0 subpriority not stored at bits 1 to 0");

    // or of every priority word, only for the reset check below
    logic [31:0] prio_or;
    always_comb
    begin
        prio_or = 32'h00000000;
        for (int i = 0; i < NUM_WORD; i++)
        begin
            prio_or = prio_or | prio_r[i];
        end
    end

    reset_clear_a: assert property ( // R18
        !$past(hresetn) |-> ((en_r == '0) && (prio_or == 32'h00000000)
        && (flag_r == '0)))
        else $error("state not clear right after reset");

    // read data selected in the address phase and held for the data phase
    always_comb
    begin
        rd_nxt = 32'h00000000;
        if (haddr[7:0] == `IEP_FLAG_OFS)
        begin
            rd_nxt[NUM_SRC-1:0] = flag_r;
        end
        else if (haddr[7:0] == `IEP_EN_OFS)
        begin
            rd_nxt[NUM_SRC-1:0] = en_r;
        end
        else if (is_prio(haddr[7:0]))
        begin
            rd_nxt = prio_r[rd_idx];
        end
    end

    // unmapped addresses and writes leave zero on the read bus
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_r <= 32'h00000000;
        end
        else if (hready)
        begin
            hrdata_r <= (take && !hwrite) ? rd_nxt : 32'h00000000;
        end
    end

    hi_unimpl_a: assert property ( // R14
        (aph_r.sel && !aph_r.wr && is_prio(aph_r.addr))
        |-> (hrdata_r[31:29] == 3'h0))
        else $error("priority word bits 31 to 29 read nonzero");

    mid_unimpl_a: assert property ( // R15
        (aph_r.sel && !aph_r.wr && is_prio(aph_r.addr))
        |-> (hrdata_r[23:21] == 3'h0))
        else $error("priority word bits 23 to 21 read nonzero");

    lo_unimpl_a: assert property ( // R16
        (aph_r.sel && !aph_r.wr && is_prio(aph_r.addr))
        |-> (hrdata_r[15:13] == 3'h0))
        else $error("priority word bits 15 to 13 read nonzero");

    // candidate sources: pending, enabled and with a nonzero priority
    // [R1] enable gates source
    // [R4] zero priority blocks
    always_comb
    begin
        for (int s = 0; s < NUM_SRC; s++)
        begin
            nz_vec[s] = prio_of(prio_r[s / `IEP_SLOTS_PER_WORD],
                                2'(s % `IEP_SLOTS_PER_WORD)) != 3'h0;
        end
        cand = flag_r & en_r & nz_vec;
    end

    // ranking by {priority, subpriority}; a strict compare keeps the
    // lowest source number on a full tie, a fixed and cheap tie rule
    // [R3] numeric priority order
    // [R5] subpriority breaks ties
    // [R19] pick the best
    always_comb
    begin
        req_nxt = '0;
        best_key = '0;
        for (int s = 0; s < NUM_SRC; s++)
        begin
            if (cand[s] && (!req_nxt.valid ||
                key_of(prio_r[s / `IEP_SLOTS_PER_WORD],
                       2'(s % `IEP_SLOTS_PER_WORD)) > best_key))
            begin
                best_key = key_of(prio_r[s / `IEP_SLOTS_PER_WORD],
                                  2'(s % `IEP_SLOTS_PER_WORD));
                req_nxt.valid = 1'b1;
                req_nxt.src = 5'(s);
                req_nxt.prio = best_key[KEY_W-1:2];
                req_nxt.sub = best_key[1:0];
            end
        end
    end

    // registered outputs toward the core; one cycle behind the flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            req_r <= req_nxt;
            irq_r <= |cand;
        end
    end

    irq_gate_a: assert property ( // R1
        irq |-> $past(|(flag_r & en_r)))
        else $error("irq raised with no enabled pending flag");

    prio_nz_a: assert property ( // R4
        core_req.valid |-> (core_req.prio != 3'h0))
        else $error("source with priority zero reached the core");

    best_pick_a: assert property ( // R19
        $past(|cand) |-> (core_req.valid &&
        ({core_req.prio, core_req.sub} == $past(best_key))))
        else $error("ranked request does not carry the best key");

    rank_prio_a: assert property ( // R3
        req_nxt.valid |=> (core_req.prio ==
        $past(prio_of(prio_r[req_nxt.src[4:2]], req_nxt.src[1:0]))))
        else $error("reported priority differs from the source field");

    rank_sub_a: assert property ( // R5
        req_nxt.valid |=> (core_req.sub ==
        $past(sub_of(prio_r[req_nxt.src[4:2]], req_nxt.src[1:0]))))
        else $error("reported subpriority differs from the source field");

    // outputs straight from flip-flops, except hresp tied to okay
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign irq = irq_r;
    assign core_req = req_r;

endmodule // iep_ctrl

// File: iep_core_model.sv
/*
 * behavioural processor core that takes ranked interrupt requests.
 * assumes: same hclk and reset as the controller, no answer goes back.
 */
`timescale 1ns/1ps
module iep_core_model (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic irq, // level request from the controller
    input wire logic slow, // one: poll only every fourth cycle
    input wire iep_pkg::iep_req_type core_req, // ranked request
    output iep_pkg::iep_req_type took // last request taken
);
    logic [1:0] tick_r;

    // a slow core polls late, so a ranking must hold until looked at
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_r <= 2'h0;
            took <= '0;
        end
        else
        begin
            tick_r <= tick_r + 2'h1;
            if (irq && (!slow || tick_r == 2'h0))
                took <= core_req;
        end
    end
endmodule // iep_core_model

// File: tb_top.sv
/*
 * self-checking bench of the enable/priority block with an integer model.
 * assumes: single ahb-lite master, zero-wait slave, core model alongside.
 */
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        n_compared++; \
        if ((a) !== (b)) \
        begin \
            err_total++; \
            $display("wrong value at %0t: got %h", $time, a); \
        end \
    end
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, slow;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, src_req, seed, en, fl, q, r;
    logic [31:0] pw [8];
    iep_pkg::iep_req_type core_req, took, exp;
    int err_total, n_compared;

    // one slave, so its ready is the bus ready
    assign hready = hreadyout;

    iep_ctrl #(.NUM_SRC(32)) dut_u (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
        .irq(irq), .core_req(core_req));
    iep_core_model core_u (.hclk(hclk), .hresetn(hresetn), .irq(irq),
        .slow(slow), .core_req(core_req), .took(took));

    // 100 ns clock
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // one single-word transfer; read data lands in q
    // waits on ready without a limit of its own; the watchdog ends a hang
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, want);
        xfer(1'b0, a, 32'h0);
        `CHK(q, want)
        `CHK(hresp, 1'b0)
    endtask

    // ranks flagged, enabled, nonzero sources; strict compare keeps the
    // lowest source number on a full tie
    task automatic check();
        int best, k, s;
        best = 0;
        exp = '0;
        repeat (6) @(posedge hclk);
        for (s = 0; s < 32; s++)
        begin
            k = (pw[s / 4] >> (8 * (s % 4))) & 31;
            if (fl[s] && en[s] && k > 3 && k > best)
            begin
                best = k;
                exp = {1'b1, 5'(s), 5'(k)};
            end
        end
        `CHK(irq, exp.valid)
        `CHK(core_req, exp)
        if (exp.valid)
        begin
            `CHK(took, exp)
        end
    endtask

    task automatic test_done();
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, src_req, slow} = '0;
        hsize = 3'h2;
        seed = 32'h20;
        {en, fl, err_total, n_compared} = '0;
        pw = '{default: 32'h0};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b0)
        `CHK(core_req, 11'h000)
        for (int i = 0; i < 12; i++) rd(4 * i, 32'h0);
        for (int it = 0; it < 12; it++)
        begin
            slow <= it[0];
            en = rnd();
            xfer(1'b1, 32'h4, en);
            rd(32'h4, en);
            for (int k = 0; k < 8; k++)
            begin
                r = rnd();
                pw[k] = r & 32'h1f1f1f1f;
                xfer(1'b1, 32'h10 + 4 * k, r);
                rd(32'h10 + 4 * k, pw[k]);
            end
            r = rnd();
            src_req <= r;
            fl |= r;
            @(posedge hclk);
            src_req <= 32'h0;
            check();
            rd(32'h0, fl);
            r = rnd();
            xfer(1'b1, 32'h0, r);
            fl &= ~r;
            check();
        end
        rd(32'h100, 32'h0);
        test_done();
    end

    // hang guard, far beyond the roughly 700 cycles the run needs
    initial
    begin
        repeat (20000) @(posedge hclk);
        err_total++;
        test_done();
    end
endmodule // tb_top
